// ### rtl/tpfs_pkg.sv
/*
 * Shared constants, register map and carrier types for the timer pin function select block.
 * Assumes a 32-bit APB master on pclk and a timer core that supplies its waveforms on pclk.
 */
package tpfs_pkg;

    // Register byte offsets, one aligned word each.
    localparam logic [7:0] OFF_PORT    = 8'h00;
    localparam logic [7:0] OFF_IRQ3    = 8'h04;
    localparam logic [7:0] OFF_ONESHOT = 8'h08;
    localparam logic [7:0] OFF_TIMER   = 8'h0C;
    localparam logic [7:0] OFF_IO      = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;

    // Port control register fields.
    localparam int PORT_DIR_BIT   = 0;
    localparam int PORT_DATA_BIT  = 1;
    localparam int PORT_DRIVE_BIT = 2;
    localparam int PORT_PULL_BIT  = 3;
    localparam int CHD_SEL_LO     = 4;
    localparam int PORT_W         = 7;

    // External interrupt three control register fields.
    localparam int IRQ3_SEL_LO  = 0;
    localparam int IRQ3_EN_BIT  = 2;
    localparam int IRQ3_CMP_BIT = 3;
    localparam int IRQ3_W       = 4;

    // One-shot timer control register fields.
    localparam int OS_MODE_LO = 0;
    localparam int OS_CTL_BIT = 2;
    localparam int OS_W       = 3;

    // Capture/compare timer control register fields.
    localparam int OD_LO      = 0;
    localparam int DUAL_BIT   = 4;
    localparam int CHAN_B_PULSE_WIDTH_SEL_BIT   = 5;
    localparam int CHAN_C_PULSE_WIDTH_SEL_BIT   = 6;
    localparam int CHAN_D_PULSE_WIDTH_SEL_BIT   = 7;
    localparam int EDGE_LO    = 8;
    localparam int TIMER_W    = 10;

    // I/O control register: one three-bit field per channel, four bits apart.
    localparam int IO_STRIDE = 4;
    localparam int IO_W      = 15;

    // Reset values.
    localparam logic [PORT_W-1:0]  PORT_RST  = 7'h00;
    localparam logic [IRQ3_W-1:0]  IRQ3_RST  = 4'h0;
    localparam logic [OS_W-1:0]    OS_RST    = 3'h0;
    localparam logic [TIMER_W-1:0] TIMER_RST = 10'h01F;
    localparam logic [IO_W-1:0]    IO_RST    = 15'h0000;

    // Field encodings.
    localparam logic [2:0] CHD_ROUTE_SEL = 3'h5;
    localparam logic [1:0] IRQ3_SEL_PIN  = 2'h2;
    localparam logic [1:0] MODE_WAVE     = 2'h1;
    localparam logic [1:0] MODE_ONESHOT  = 2'h2;
    localparam logic [1:0] MODE_WAIT     = 2'h3;

    // Waveforms produced by the timer cores.
    typedef struct packed {
        logic       os_pulse;
        logic       os_prog;
        logic       os_single;
        logic       os_wait;
        logic       dual_pwm;
        logic [3:0] pwm;
        logic [3:0] compare;
    } tpfs_wave_s;

    // Inputs handed back to the timer cores.
    typedef struct packed {
        logic [3:0] capture_en;
        logic [3:0] capture_lvl;
        logic       trigger_en;
        logic       trigger_lvl;
    } tpfs_tin_s;

    // Compare drive codes are 001 and 01X.
    function automatic logic tpfs_is_compare(input logic [2:0] io);
        return (io == 3'h1) || (io[2:1] == 2'h1);
    endfunction

endpackage

// ### rtl/tpfs_sync.sv
/*
 * Three-stage synchroniser with agreement filter for asynchronous pin levels.
 * Assumes inputs may change at any time relative to pclk.
 */
`timescale 1ns/1ns
module tpfs_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit moves only once the second and third stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ### rtl/tpfs_chan_mux.sv
/*
 * Function decode for one capture/compare channel pin.
 * Assumes the caller registers the results before they reach a pad.
 */
`timescale 1ns/1ns
module tpfs_chan_mux (
    // Channel controls
    input  wire logic       out_disable,
    input  wire logic       dual_sel,
    input  wire logic       pwm_bit,
    input  wire logic       dual_capable,
    input  wire logic [2:0] io_ctl,
    // Waveforms
    input  wire logic       dual_wave,
    input  wire logic       pwm_wave,
    input  wire logic       cmp_wave,
    // Results
    output logic            pin_out,
    output logic            pin_oe,
    output logic            capture_en
);
    import tpfs_pkg::*;

    always_comb begin
        pin_out    = 1'b0;
        pin_oe     = 1'b0;
        capture_en = 1'b0;
        if (!dual_sel) begin
            if (dual_capable && !out_disable) begin
                pin_out = dual_wave;
                pin_oe  = 1'b1;
            end
        end else if (pwm_bit) begin
            if (!out_disable) begin
                pin_out = pwm_wave;
                pin_oe  = 1'b1;
            end
        end else if (io_ctl[2]) begin
            capture_en = 1'b1;
        end else if (!out_disable && tpfs_is_compare(io_ctl)) begin
            pin_out = cmp_wave;
            pin_oe  = 1'b1;
        end
    end
endmodule

// ### rtl/tpfs_top.sv
/*
 * Timer pin function select: APB registers and the pin multiplexer for the shared port pin,
 * the one-shot timer output pin and the three capture/compare channel pins.
 * Assumes a 32-bit APB master on pclk, pad levels arriving asynchronously, and timer
 * waveforms arriving on pclk from the timer cores.
 */
// Design decisions made here: the APB interface to the registers and the address map.
// Overview of operation
// - The shared pin is a plain port unless the channel-D select is 101b, which hands it to channel D.
// - The shared pin feeds external interrupt three only for input, select 10, enable 1, source 0, no channel D.
// - A driven shared pin switches to high drive strength while its drive bit is set.
// - Timer mode 01 with output control 0 puts the pulse waveform on the one-shot timer pin.
// - Timer mode 01 with output control 1 puts the programmable output on the one-shot timer pin.
// - With output control 0, mode 10 drives the one-shot output and mode 11 the wait one-shot output.
// - Channel A is the dual-compare trigger input when disabled, dual select 0 and edge field 01 or 1X.
// - Channel B drives the dual-compare waveform when enabled and dual select is 0, ignoring its other bits.
// - Channels B, C and D drive their PWM waveform when enabled, dual select 1 and PWM bit 1.
// - A channel drives its compare waveform when enabled, dual select 1, PWM bit 0 and I/O code 001 or 01X.
// - A channel is a capture input when dual select 1, PWM bit 0 and I/O top bit 1, whatever its disable bit.
`timescale 1ns/1ns
module tpfs_top (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Timer side
    input  wire tpfs_pkg::tpfs_wave_s wave,
    output tpfs_pkg::tpfs_tin_s       timer_in,
    output logic                     irq3_level,
    // Shared port pin
    input  wire logic                shared_pin_i,
    output logic                     shared_pin_o,
    output logic                     shared_pin_oe,
    output logic                     shared_pin_hi_drive,
    output logic                     shared_pin_pullup,
    // One-shot timer output pin
    output logic                     oneshot_pin_o,
    output logic                     oneshot_pin_oe,
    // Channel A to C pins
    input  wire logic [2:0]          chan_pin_i,
    output logic      [2:0]          chan_pin_o,
    output logic      [2:0]          chan_pin_oe
);
    import tpfs_pkg::*;

    logic [PORT_W-1:0]  port_q;
    logic [IRQ3_W-1:0]  irq3_q;
    logic [OS_W-1:0]    os_q;
    logic [TIMER_W-1:0] timer_q;
    logic [IO_W-1:0]    io_q;

    logic [3:0]  pin_lvl;
    logic [3:0]  ch_out;
    logic [3:0]  ch_oe;
    logic [3:0]  ch_cap;
    logic [3:0]  pwm_bits;
    logic [3:0]  dual_cap;
    logic [2:0]  chd_sel;
    logic        chd_routed;
    logic        irq3_hit;
    logic        trig_hit;
    logic        sh_out_d;
    logic        sh_oe_d;
    logic        os_out_d;
    logic        os_oe_d;
    logic        wr_en;
    logic        acc_done;
    logic        hit;
    logic [31:0] rd_d;

    // APB access phase.
    // One wait state lets read data and the error flag come from flops.
    assign acc_done = psel && penable && pready;
    assign wr_en    = acc_done && pwrite;

    always_comb begin
        hit  = 1'b1;
        rd_d = 32'h0000_0000;
        unique case (paddr)
            OFF_PORT:    rd_d[PORT_W-1:0]  = port_q;
            OFF_IRQ3:    rd_d[IRQ3_W-1:0]  = irq3_q;
            OFF_ONESHOT: rd_d[OS_W-1:0]    = os_q;
            OFF_TIMER:   rd_d[TIMER_W-1:0] = timer_q;
            OFF_IO:      rd_d[IO_W-1:0]    = io_q;
            OFF_STATUS: begin
                rd_d[3:0]   = pin_lvl;
                rd_d[7:4]   = {shared_pin_oe, chan_pin_oe};
                rd_d[11:8]  = timer_in.capture_en;
                rd_d[12]    = timer_in.trigger_en;
                rd_d[13]    = irq3_level;
                rd_d[14]    = oneshot_pin_oe;
                rd_d[15]    = shared_pin_hi_drive;
            end
            default:     hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    // Writes land on the edge where the master samples pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_q  <= PORT_RST;
            irq3_q  <= IRQ3_RST;
            os_q    <= OS_RST;
            timer_q <= TIMER_RST;
            io_q    <= IO_RST;
        end else if (wr_en) begin
            case (paddr)
                OFF_PORT:    port_q  <= pwdata[PORT_W-1:0];
                OFF_IRQ3:    irq3_q  <= pwdata[IRQ3_W-1:0];
                OFF_ONESHOT: os_q    <= pwdata[OS_W-1:0];
                OFF_TIMER:   timer_q <= pwdata[TIMER_W-1:0];
                OFF_IO:      io_q    <= pwdata[IO_W-1:0];
                default:     ;
            endcase
        end
    end

    // Pad levels, channel D last since it shares the port pin.
    tpfs_sync #(
        .WIDTH(4)
    ) u_sync (
        .pclk   (pclk),
        .presetn(presetn),
        .async_i({shared_pin_i, chan_pin_i}),
        .level_q(pin_lvl)
    );

    assign pwm_bits = {timer_q[CHAN_D_PULSE_WIDTH_SEL_BIT], timer_q[CHAN_C_PULSE_WIDTH_SEL_BIT], timer_q[CHAN_B_PULSE_WIDTH_SEL_BIT], 1'b0};
    assign dual_cap = 4'h2;

    // Channel A has no PWM bit and only channel B carries the dual-compare waveform.
    for (genvar c = 0; c < 4; c++) begin : g_chan
        tpfs_chan_mux u_mux (
            .out_disable (timer_q[OD_LO+c]),
            .dual_sel    (timer_q[DUAL_BIT]),
            .pwm_bit     (pwm_bits[c]),
            .dual_capable(dual_cap[c]),
            .io_ctl      (io_q[c*IO_STRIDE +: 3]),
            .dual_wave   (wave.dual_pwm),
            .pwm_wave    (wave.pwm[c]),
            .cmp_wave    (wave.compare[c]),
            .pin_out     (ch_out[c]),
            .pin_oe      (ch_oe[c]),
            .capture_en  (ch_cap[c])
        );
    end

    assign chd_sel    = port_q[CHD_SEL_LO +: 3];
    assign chd_routed = (chd_sel == CHD_ROUTE_SEL);

    // The port direction bit only matters while channel D does not own the pin.
    always_comb begin
        if (chd_routed) begin
            sh_out_d = ch_out[3];
            sh_oe_d  = ch_oe[3];
        end else begin
            sh_out_d = port_q[PORT_DATA_BIT];
            sh_oe_d  = port_q[PORT_DIR_BIT];
        end
    end

    assign irq3_hit = !port_q[PORT_DIR_BIT] && !chd_routed
        && (irq3_q[IRQ3_SEL_LO +: 2] == IRQ3_SEL_PIN)
        && irq3_q[IRQ3_EN_BIT] && !irq3_q[IRQ3_CMP_BIT];

    assign trig_hit = timer_q[OD_LO] && !timer_q[DUAL_BIT]
        && ((timer_q[EDGE_LO +: 2] == 2'h1) || timer_q[EDGE_LO+1]);

    // Unlisted mode and control pairs leave the one-shot pin undriven.
    always_comb begin
        os_out_d = 1'b0;
        os_oe_d  = 1'b1;
        unique case (os_q[OS_MODE_LO +: 2])
            MODE_WAVE: os_out_d = os_q[OS_CTL_BIT] ? wave.os_prog : wave.os_pulse;
            MODE_ONESHOT: begin
                os_out_d = wave.os_single;
                os_oe_d  = !os_q[OS_CTL_BIT];
            end
            MODE_WAIT: begin
                os_out_d = wave.os_wait;
                os_oe_d  = !os_q[OS_CTL_BIT];
            end
            default:   os_oe_d = 1'b0;
        endcase
        if (!os_oe_d) begin
            os_out_d = 1'b0;
        end
    end

    // Pad-facing outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_pin_o        <= 1'b0;
            shared_pin_oe       <= 1'b0;
            shared_pin_hi_drive <= 1'b0;
            shared_pin_pullup   <= 1'b0;
            chan_pin_o          <= 3'h0;
            chan_pin_oe         <= 3'h0;
            oneshot_pin_o       <= 1'b0;
            oneshot_pin_oe      <= 1'b0;
        end else begin
            shared_pin_o        <= sh_out_d;
            shared_pin_oe       <= sh_oe_d;
            shared_pin_hi_drive <= sh_oe_d && port_q[PORT_DRIVE_BIT];
            shared_pin_pullup   <= !sh_oe_d && port_q[PORT_PULL_BIT];
            chan_pin_o          <= ch_out[2:0];
            chan_pin_oe         <= ch_oe[2:0];
            oneshot_pin_o       <= os_out_d;
            oneshot_pin_oe      <= os_oe_d;
        end
    end

    // Timer-facing inputs; a disabled function shows a low level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_in   <= '0;
            irq3_level <= 1'b0;
        end else begin
            timer_in.capture_en     <= {ch_cap[3] && chd_routed, ch_cap[2:0]};
            timer_in.capture_lvl    <= {ch_cap[3] && chd_routed, ch_cap[2:0]} & pin_lvl;
            timer_in.trigger_en     <= trig_hit;
            timer_in.trigger_lvl    <= trig_hit && pin_lvl[0];
            irq3_level              <= irq3_hit && pin_lvl[3];
        end
    end

    port_mode_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !chd_routed |=> (shared_pin_oe == $past(port_q[PORT_DIR_BIT]))
            && (shared_pin_o == $past(port_q[PORT_DATA_BIT])))
        else $error("Shared pin does not act as a plain port.");

    chan_d_route_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (chd_routed && ch_oe[3]) |=> shared_pin_oe && (shared_pin_o == $past(ch_out[3])))
        else $error("Shared pin is not driven by channel D.");

    irq3_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (port_q[PORT_DIR_BIT] || chd_routed || !irq3_q[IRQ3_EN_BIT]
            || irq3_q[IRQ3_CMP_BIT]) |=> !irq3_level)
        else $error("Interrupt three level passes while its path is closed.");

    irq3_follow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq3_hit && pin_lvl[3]) |=> irq3_level)
        else $error("Interrupt three misses the pin level.");

    hi_drive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        shared_pin_hi_drive |-> shared_pin_oe && $past(port_q[PORT_DRIVE_BIT]))
        else $error("High drive without an output or drive bit.");

    wave_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (os_q == {1'b0, MODE_WAVE}) |=> oneshot_pin_oe
            && (oneshot_pin_o == $past(wave.os_pulse)))
        else $error("One-shot pin lacks the pulse waveform.");

    wave_prog_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (os_q == {1'b1, MODE_WAVE}) |=> oneshot_pin_oe
            && (oneshot_pin_o == $past(wave.os_prog)))
        else $error("One-shot pin lacks the programmable output.");

    oneshot_modes_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (os_q == {1'b0, MODE_ONESHOT}) |=> oneshot_pin_oe
            && (oneshot_pin_o == $past(wave.os_single)))
        else $error("One-shot pin lacks the one-shot output.");

    wait_mode_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (os_q == {1'b0, MODE_WAIT}) |=> oneshot_pin_oe
            && (oneshot_pin_o == $past(wave.os_wait)))
        else $error("One-shot pin lacks the wait one-shot output.");

    trigger_in_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        timer_in.trigger_en |-> $past(timer_q[OD_LO]) && !$past(timer_q[DUAL_BIT])
            && ($past(timer_q[EDGE_LO +: 2]) != 2'h0))
        else $error("Trigger input enabled in a wrong setting.");

    dual_wave_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!timer_q[DUAL_BIT] && !timer_q[OD_LO+1]) |=> chan_pin_oe[1]
            && (chan_pin_o[1] == $past(wave.dual_pwm)) && !chan_pin_oe[0])
        else $error("Channel B lacks the dual-compare waveform.");

    pwm_wave_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timer_q[DUAL_BIT] && timer_q[CHAN_C_PULSE_WIDTH_SEL_BIT] && !timer_q[OD_LO+2])
            |=> chan_pin_oe[2] && (chan_pin_o[2] == $past(wave.pwm[2])))
        else $error("Channel C lacks the PWM waveform.");

    compare_wave_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timer_q[DUAL_BIT] && !timer_q[OD_LO] && tpfs_is_compare(io_q[2:0]))
            |=> chan_pin_oe[0] && (chan_pin_o[0] == $past(wave.compare[0])))
        else $error("Channel A lacks the compare waveform.");

    capture_in_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (timer_q[DUAL_BIT] && io_q[2] && $stable(timer_q) && $stable(io_q))
            |=> timer_in.capture_en[0] && !chan_pin_oe[0])
        else $error("Channel A is not a capture input.");

endmodule

// ### verification/tpfs_board.sv
/*
 * Board model for the pads of the timer pin function select block.
 * Assumes the bench sets the level that outside circuitry drives on pads the chip leaves alone.
 */
`timescale 1ns/1ns
module tpfs_board (
    // Chip side
    input  wire logic       sh_o,
    input  wire logic       sh_oe,
    input  wire logic       sh_pull,
    input  wire logic [2:0] ch_o,
    input  wire logic [2:0] ch_oe,
    // Outside levels
    input  wire logic       ext_sh,
    input  wire logic [2:0] ext_ch,
    // Pad levels seen by the chip
    output logic            sh_pad,
    output logic [2:0]      ch_pad
);
    // The outside driver lets go while the pull-up is on, so the pad then reads high.
    assign sh_pad = sh_oe ? sh_o : (sh_pull | ext_sh);
    assign ch_pad = (ch_oe & ch_o) | (~ch_oe & ext_ch);
endmodule

// ### verification/test_timer_pin_function_select.sv
/*
 * Self-checking bench for the timer pin function select block with a board model on its pads.
 * Assumes the APB slave answers with pready within a few cycles.
 */
`timescale 1ns/1ns
module test_timer_pin_function_select;
    import tpfs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    tpfs_wave_s  wave;
    tpfs_tin_s   tin;
    logic        irq3, sh_i, sh_o, sh_oe, sh_hi, sh_pull, os_o, os_oe, ext_sh;
    logic [2:0]  ch_i, ch_o, ch_oe, ext_ch;
    int          failures, n_tests;

    tpfs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wave(wave), .timer_in(tin), .irq3_level(irq3),
        .shared_pin_i(sh_i), .shared_pin_o(sh_o), .shared_pin_oe(sh_oe),
        .shared_pin_hi_drive(sh_hi), .shared_pin_pullup(sh_pull), .oneshot_pin_o(os_o),
        .oneshot_pin_oe(os_oe), .chan_pin_i(ch_i), .chan_pin_o(ch_o), .chan_pin_oe(ch_oe));
    tpfs_board board_u (.sh_o(sh_o), .sh_oe(sh_oe), .sh_pull(sh_pull), .ch_o(ch_o),
        .ch_oe(ch_oe), .ext_sh(ext_sh), .ext_ch(ext_ch), .sh_pad(sh_i), .ch_pad(ch_i));

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic void exp_chan(input int x, input logic [9:0] t, input logic [14:0] io,
        input tpfs_wave_s w, output logic o, output logic oe, output logic cap);
        logic [2:0] c;
        logic       pb;
        c = io[x*4 +: 3];
        pb = (x > 0) ? t[4+x] : 1'h0;
        o = 1'h0;
        oe = 1'h0;
        cap = 1'h0;
        if (!t[4]) begin
            oe = (x == 1) && !t[1];
            o = w.dual_pwm;
        end else if (pb) begin
            oe = !t[x];
            o = w.pwm[x];
        end else if (c[2]) begin
            cap = 1'h1;
        end else begin
            oe = !t[x] && (c == 3'h1 || c[2:1] == 2'h1);
            o = w.compare[x];
        end
    endfunction

    function automatic logic [1:0] exp_os(input logic [2:0] m, input tpfs_wave_s w);
        case (m)
            3'h1: return {1'h1, w.os_pulse};
            3'h5: return {1'h1, w.os_prog};
            3'h2: return {1'h1, w.os_single};
            3'h3: return {1'h1, w.os_wait};
            default: return 2'h0;
        endcase
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (k == 16) begin
            failures++;
            wrap_up();
        end
    endtask

    initial begin
        logic [31:0] r, r2;
        logic [9:0]  t;
        logic [14:0] io;
        logic [6:0]  pt;
        logic [3:0]  iq, eo, eoe, ecap;
        logic [2:0]  os, cpad;
        logic        don, soe, so, spad, trg, path;
        logic [1:0]  eos;
        int          i, x;
        seed = 32'h0000_4cf4;
        failures = 0;
        n_tests = 0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        wave = '0;
        ext_sh = 1'h0;
        ext_ch = 3'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        chk("chan oe at reset", 32'h0000_0000, ch_oe);
        for (i = 0; i < 6; i++) begin
            apb(1'h0, (i == 5) ? 8'h18 : 8'(i * 4), 32'h0000_0000);
            chk("reset read", (i == 3) ? 32'h0000_001F : 32'h0000_0000, rd);
            chk("slave error", i == 5, err);
        end
        apb(1'h1, 8'hFC, 32'hFFFF_FFFF);
        chk("write error", 32'h0000_0001, err);
        for (i = 0; i < 80; i++) begin
            r = rnd();
            r2 = rnd();
            t = r[9:0];
            io = r[24:10];
            pt = {i[1] ? CHD_ROUTE_SEL : r[27:25], r[31:28]};
            iq = i[0] ? 4'h6 : r2[3:0];
            os = (i < 8) ? 3'(i) : r2[6:4];
            apb(1'h1, OFF_PORT, {25'h0, pt});
            apb(1'h1, OFF_IRQ3, {28'h0, iq});
            apb(1'h1, OFF_ONESHOT, {29'h0, os});
            apb(1'h1, OFF_TIMER, {22'h0, t});
            apb(1'h1, OFF_IO, {17'h0, io});
            wave <= tpfs_wave_s'(r2[29:17]);
            ext_ch <= r2[9:7];
            ext_sh <= r2[10];
            repeat (9) @(posedge pclk);
            for (x = 0; x < 4; x++) begin
                exp_chan(x, t, io, wave, eo[x], eoe[x], ecap[x]);
            end
            don = (pt[6:4] == CHD_ROUTE_SEL);
            ecap[3] = ecap[3] & don;
            soe = don ? eoe[3] : pt[0];
            so = don ? eo[3] : pt[1];
            spad = soe ? so : (pt[3] | ext_sh);
            cpad = (eoe[2:0] & eo[2:0]) | (~eoe[2:0] & ext_ch);
            trg = !t[4] && t[0] && (t[9:8] != 2'h0);
            path = !pt[0] && (iq == 4'h6) && !don;
            chk("shared pin", {soe, soe & so}, {sh_oe, sh_oe & sh_o});
            chk("high drive", pt[2] & soe, sh_hi);
            chk("pull-up", pt[3] & !soe, sh_pull);
            chk("irq3 level", path & spad, irq3);
            chk("one-shot pin", exp_os(os, wave), {os_oe, os_oe & os_o});
            chk("chan oe", eoe[2:0], ch_oe);
            chk("chan out", eoe[2:0] & eo[2:0], ch_oe & ch_o);
            chk("capture en", ecap, tin.capture_en);
            chk("capture lvl", ecap & {spad, cpad}, tin.capture_lvl);
            chk("trigger", {trg, trg & cpad[0]}, {tin.trigger_en, tin.trigger_lvl});
            apb(1'h0, OFF_TIMER, 32'h0000_0000);
            chk("timer readback", {22'h0, t}, rd);
            eos = exp_os(os, wave);
            apb(1'h0, OFF_STATUS, 32'h0000_0000);
            r = {16'h0, pt[2] & soe, eos[1], path & spad, trg, ecap, soe, eoe[2:0], spad, cpad};
            chk("status", r, rd);
        end
        wrap_up();
    end
endmodule
